/* File: hw/adc_window_detector.sv */
/*
 * ADC window detector: conversion sequencer, result formatting,
 * window limits and sticky match flag behind an AXI4-Lite slave.
 * Assumes a synchronous converter code on adcCode, valid when the
 * tenth converter clock of a conversion ends.
 */
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module adc_window_detector
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// axi4-lite write address
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// axi4-lite read address
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// converter side
	input  wire logic              convStart,
	input  wire logic [9:0]        adcCode,
	output logic                   convBusy,
	output logic                   resultStrobe,
	// window match request
	output logic                   windowMatchFlag
);

	// write path state
	logic                  awHeld_q;
	logic                  wHeld_q;
	logic [9:0]            wIdx_q;
	logic [7:0]            wByte_q;
	logic                  wLane_q;
	logic                  doWrite;
	logic                  wrMapped;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	// read path state
	logic                  rvalid_q;
	logic [31:0]           rdata_q;
	logic [1:0]            rresp_q;
	logic [9:0]            rIdx;
	logic [7:0]            rByte;
	logic                  rdMapped;
	// registers
	logic [7:0]            ltLow_q;
	logic [7:0]            ltHigh_q;
	logic [7:0]            gtLow_q;
	logic [7:0]            gtHigh_q;
	logic [4:0]            negSel_q;
	logic                  leftJust_q;
	logic [4:0]            sarDiv_q;
	logic [15:0]           resultWord_q;
	logic                  flag_q;
	// conversion and compare
	adc_window_pkg::conv_state_e convState_q;
	logic [4:0]            sarCnt_q;
	logic [3:0]            sarClks_q;
	logic                  sarTick;
	logic                  convDone;
	logic                  differential;
	logic [15:0]           fmtWord;
	logic                  winMatch;
	logic                  clrFlag;

	// handshakes; one write and one read in flight at a time
	assign s_axi_awready = !awHeld_q && !bvalid_q;
	assign s_axi_wready  = !wHeld_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign doWrite       = awHeld_q && wHeld_q;

	// address and data may arrive in either order
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			wIdx_q   <= 10'h000;
			wByte_q  <= 8'h00;
			wLane_q  <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_q <= 1'b1;
				wIdx_q   <= s_axi_awaddr[11:2];
			end
			else if (doWrite)
				awHeld_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_q <= 1'b1;
				wByte_q <= s_axi_wdata[7:0];
				wLane_q <= s_axi_wstrb[0];
			end
			else if (doWrite)
				wHeld_q <= 1'b0;
		end
	end

	// writable indices; everything else answers slverr
	always_comb
	begin
		unique case (wIdx_q)
			adc_window_pkg::IDX_LT_LOW,
			adc_window_pkg::IDX_LT_HIGH,
			adc_window_pkg::IDX_GT_LOW,
			adc_window_pkg::IDX_GT_HIGH,
			adc_window_pkg::IDX_CONFIG,
			adc_window_pkg::IDX_SARDIV,
			adc_window_pkg::IDX_STATUS: wrMapped = 1'b1;
			default:                    wrMapped = 1'b0;
		endcase
	end

	// write response, held until bready
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= adc_window_pkg::RESP_OKAY;
		end
		else if (doWrite)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= wrMapped ? adc_window_pkg::RESP_OKAY
				: adc_window_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// [R11] [R3] limit bytes
	// a write with byte lane 0 off is answered but stores nothing
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ltLow_q  <= adc_window_pkg::RST_LIMIT;
			ltHigh_q <= adc_window_pkg::RST_LIMIT;
			gtLow_q  <= adc_window_pkg::RST_LIMIT;
			gtHigh_q <= adc_window_pkg::RST_LIMIT;
		end
		else if (doWrite && wLane_q)
		begin
			if (wIdx_q == adc_window_pkg::IDX_LT_LOW)
				ltLow_q <= wByte_q;
			if (wIdx_q == adc_window_pkg::IDX_LT_HIGH)
				ltHigh_q <= wByte_q;
			if (wIdx_q == adc_window_pkg::IDX_GT_LOW)
				gtLow_q <= wByte_q;
			if (wIdx_q == adc_window_pkg::IDX_GT_HIGH)
				gtHigh_q <= wByte_q;
		end
	end

	// format and converter clock configuration
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			negSel_q   <= adc_window_pkg::RST_NEG_SEL;
			leftJust_q <= 1'b0;
			sarDiv_q   <= adc_window_pkg::RST_SAR_DIV;
		end
		else if (doWrite && wLane_q)
		begin
			if (wIdx_q == adc_window_pkg::IDX_CONFIG)
			begin
				negSel_q   <= wByte_q[adc_window_pkg::CFG_NEG_LSB +: 5];
				leftJust_q <= wByte_q[adc_window_pkg::CFG_LJUST_BIT];
			end
			if (wIdx_q == adc_window_pkg::IDX_SARDIV)
				sarDiv_q <= wByte_q[4:0];
		end
	end

	// [R16] ground negative input is single-ended
	assign differential = negSel_q != adc_window_pkg::NEG_SEL_GND;

	// [R12] converter clock enable
	// divide by sarDiv+1; counting stops while idle to save power
	assign sarTick  = (convState_q == adc_window_pkg::CONV_RUN)
		&& (sarCnt_q == sarDiv_q);
	assign convDone = sarTick
		&& (sarClks_q == adc_window_pkg::CONV_SAR_CLOCKS - 4'h1);
	assign convBusy     = convState_q == adc_window_pkg::CONV_RUN;
	assign resultStrobe = convDone;

	// [R12] ten converter clocks per conversion
	// a start while busy is dropped, not queued
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			convState_q <= adc_window_pkg::CONV_IDLE;
			sarCnt_q    <= 5'h00;
			sarClks_q   <= 4'h0;
		end
		else
		begin
			unique case (convState_q)
				adc_window_pkg::CONV_IDLE:
				begin
					sarCnt_q  <= 5'h00;
					sarClks_q <= 4'h0;
					if (convStart)
						convState_q <= adc_window_pkg::CONV_RUN;
				end
				adc_window_pkg::CONV_RUN:
				begin
					sarCnt_q <= sarTick ? 5'h00 : sarCnt_q + 5'h01;
					if (sarTick)
						sarClks_q <= sarClks_q + 4'h1;
					if (convDone)
						convState_q <= adc_window_pkg::CONV_IDLE;
				end
			endcase
		end
	end

	// [R14] [R15] justify the new code
	assign fmtWord = leftJust_q ? {adcCode, 6'h00}
		: {{6{adcCode[9]}}, adcCode};

	// [R1] [R4] compare without software
	window_compare u_compare
	(
		.resultWord   (fmtWord),
		.gtLimit      ({gtHigh_q, gtLow_q}),
		.ltLimit      ({ltHigh_q, ltLow_q}),
		.differential (differential),
		.leftJustify  (leftJust_q),
		.match        (winMatch)
	);

	// [R18] result write and compare coincide
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			resultWord_q <= 16'h0000;
		else if (convDone)
			resultWord_q <= fmtWord;
	end

	// [R13] sticky flag, set beats clear
	// written 1 clears; a match in the same cycle keeps it set
	assign clrFlag = doWrite && wLane_q
		&& (wIdx_q == adc_window_pkg::IDX_STATUS)
		&& wByte_q[adc_window_pkg::STAT_FLAG_BIT];
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			flag_q <= 1'b0;
		else if (convDone && winMatch)
			flag_q <= 1'b1;
		else if (clrFlag)
			flag_q <= 1'b0;
	end
	assign windowMatchFlag = flag_q;

	// read mux; unused bits read zero
	assign rIdx = s_axi_araddr[11:2];
	always_comb
	begin
		rByte    = 8'h00;
		rdMapped = 1'b1;
		unique case (rIdx)
			adc_window_pkg::IDX_LT_LOW:   rByte = ltLow_q;
			adc_window_pkg::IDX_LT_HIGH:  rByte = ltHigh_q;
			adc_window_pkg::IDX_GT_LOW:   rByte = gtLow_q;
			adc_window_pkg::IDX_GT_HIGH:  rByte = gtHigh_q;
			adc_window_pkg::IDX_CONFIG:   rByte = {2'h0, leftJust_q, negSel_q};
			adc_window_pkg::IDX_SARDIV:   rByte = {3'h0, sarDiv_q};
			adc_window_pkg::IDX_STATUS:   rByte = {6'h00, convBusy, flag_q};
			adc_window_pkg::IDX_RES_LOW:  rByte = resultWord_q[7:0];
			adc_window_pkg::IDX_RES_HIGH: rByte = resultWord_q[15:8];
			default:                      rdMapped = 1'b0;
		endcase
	end

	// [R2] read data registered
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= adc_window_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rByte};
			rresp_q  <= rdMapped ? adc_window_pkg::RESP_OKAY
				: adc_window_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// helper: cycles since the previous result, saturating
	logic [7:0] gap_q;
	logic       seen_q;
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			gap_q  <= 8'h00;
			seen_q <= 1'b0;
		end
		else if (convDone)
		begin
			gap_q  <= 8'h01;
			seen_q <= 1'b1;
		end
		else if (gap_q != 8'hff)
			gap_q <= gap_q + 8'h01;
	end

	a_flag_sets_match: // [R13]
	assert property (@(posedge clk) disable iff (sys_rst)
		convDone && winMatch |=> windowMatchFlag)
		else $error("match did not set the flag");

	a_flag_stays_set: // [R13]
	assert property (@(posedge clk) disable iff (sys_rst)
		windowMatchFlag && !clrFlag |=> windowMatchFlag)
		else $error("flag dropped without a clear");

	a_flag_no_cause: // [R1]
	assert property (@(posedge clk) disable iff (sys_rst)
		!windowMatchFlag && !(convDone && winMatch) |=> !windowMatchFlag)
		else $error("flag rose without a match");

	a_result_spacing: // [R12]
	assert property (@(posedge clk) disable iff (sys_rst)
		resultStrobe && seen_q |-> gap_q >= 8'h0b)
		else $error("results closer than ten converter clocks");

	a_lt_byte_write: // [R11]
	assert property (@(posedge clk) disable iff (sys_rst)
		doWrite && wLane_q && wIdx_q == adc_window_pkg::IDX_LT_LOW
		|=> ltLow_q == $past(wByte_q))
		else $error("less-than low byte not stored");

	a_right_justify: // [R14]
	assert property (@(posedge clk) disable iff (sys_rst)
		resultStrobe && !leftJust_q |=> resultWord_q[9:0] == $past(adcCode)
		&& resultWord_q[15:10] == {6{resultWord_q[9]}})
		else $error("right-justified result wrong");

	a_left_justify: // [R15]
	assert property (@(posedge clk) disable iff (sys_rst)
		resultStrobe && leftJust_q |=> resultWord_q[15:6] == $past(adcCode)
		&& resultWord_q[5:0] == 6'h00)
		else $error("left-justified result wrong");

	a_inside_single: // [R5]
	assert property (@(posedge clk) disable iff (sys_rst)
		resultStrobe && !differential && !leftJust_q
		&& ltHigh_q[1:0] == 2'h0 && ltLow_q == 8'h80
		&& gtHigh_q[1:0] == 2'h0 && gtLow_q == 8'h40
		|-> winMatch == (adcCode > 10'h040 && adcCode < 10'h080))
		else $error("single-ended inside window wrong");

	a_outside_single: // [R6]
	assert property (@(posedge clk) disable iff (sys_rst)
		resultStrobe && !differential && !leftJust_q
		&& ltHigh_q[1:0] == 2'h0 && ltLow_q == 8'h40
		&& gtHigh_q[1:0] == 2'h0 && gtLow_q == 8'h80
		|-> winMatch == (adcCode < 10'h040 || adcCode > 10'h080))
		else $error("single-ended outside window wrong");

	a_diff_minus_one: // [R9]
	assert property (@(posedge clk) disable iff (sys_rst)
		resultStrobe && differential && !leftJust_q
		&& {gtHigh_q, gtLow_q} == 16'hffff
		&& {ltHigh_q, ltLow_q} == 16'h0040 && adcCode == 10'h000
		|=> windowMatchFlag)
		else $error("zero not inside (-1, 64) window");

	a_diff_outside: // [R10]
	assert property (@(posedge clk) disable iff (sys_rst)
		resultStrobe && differential && !leftJust_q
		&& {ltHigh_q, ltLow_q} == 16'hffff
		&& {gtHigh_q, gtLow_q} == 16'h0040 && adcCode == 10'h3fe
		|-> winMatch)
		else $error("-2 not outside the window");

	a_status_read: // [R2]
	assert property (@(posedge clk) disable iff (sys_rst)
		s_axi_arvalid && s_axi_arready
		&& rIdx == adc_window_pkg::IDX_STATUS
		|=> s_axi_rvalid && s_axi_rdata[0] == $past(windowMatchFlag))
		else $error("status read missed the flag");

endmodule : adc_window_detector

`default_nettype wire

/* File: hw/window_compare.sv */
/*
 * Window comparison of one result word against two limit words.
 * Assumes all three words share the current justification and sign.
 */
`timescale 1ns/100ps
`default_nettype none

module window_compare
(
	// words to compare
	input  wire logic [15:0] resultWord,
	input  wire logic [15:0] gtLimit,
	input  wire logic [15:0] ltLimit,
	// format
	input  wire logic        differential,
	input  wire logic        leftJustify,
	// answer
	output logic             match
);

	logic [9:0]         res10;
	logic [9:0]         gt10;
	logic [9:0]         lt10;
	logic signed [10:0] resS;
	logic signed [10:0] gtS;
	logic signed [10:0] ltS;

	// [R4] raw words taken as written
	// pick the 10 data bits; padding bits never influence the answer
	assign res10 = leftJustify ? resultWord[15:6] : resultWord[9:0];
	assign gt10  = leftJustify ? gtLimit[15:6] : gtLimit[9:0];
	assign lt10  = leftJustify ? ltLimit[15:6] : ltLimit[9:0];

	// [R7] [R8] unsigned or sign extended
	// an 11th bit makes one signed comparator serve both modes
	assign resS = {differential & res10[9], res10};
	assign gtS  = {differential & gt10[9], gt10};
	assign ltS  = {differential & lt10[9], lt10};

	// [R17] [R5] [R6] [R9] [R10] window test
	always_comb
	begin
		if (ltS > gtS)
			match = (resS > gtS) && (resS < ltS);
		else
			match = (resS < ltS) || (resS > gtS);
	end

endmodule : window_compare

`default_nettype wire

/* File: inc/adc_window_pkg.sv */
/*
 * Constants, register map and types of the ADC window detector.
 * Assumes a single 100 MHz clock and an AXI4-Lite register bus.
 */
// What this block does
// [R1] compare every finished conversion against limits
// [R2] match flag readable by polling, drives request
// [R3] two limits, each a high and low byte
// [R4] software writes limits in result format
// [R5] inside window: strictly between both limits
// [R6] outside window: strictly beyond either limit
// [R7] single-ended: compare as 10-bit unsigned
// [R8] differential: compare as signed two's complement
// [R9] differential all-ones limit acts as minus one
// [R10] differential outside: below -1 or above limit
// [R11] less-than bytes eight bits, RW, reset zero
// [R12] one result per ten converter clocks
// [R13] match flag sticky until software clears
// [R14] right justify: high byte sign-extends bit1
// [R15] left justify: top eight bits, low padded
// [R16] ground negative input means single-ended mode
// [R17] lt above gt selects inside, else outside
// [R18] compare in the cycle result is written
package adc_window_pkg;

	// bus geometry; register index = byte address / 4
	localparam int          ADDR_W = 12;
	localparam int          IDX_W  = 10;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// register indices
	localparam logic [9:0]  IDX_LT_LOW  = 10'h0c5;
	localparam logic [9:0]  IDX_LT_HIGH = 10'h0c6;
	localparam logic [9:0]  IDX_GT_LOW  = 10'h0c7;
	localparam logic [9:0]  IDX_GT_HIGH = 10'h0c8;
	localparam logic [9:0]  IDX_CONFIG  = 10'h0c9;
	localparam logic [9:0]  IDX_SARDIV  = 10'h0ca;
	localparam logic [9:0]  IDX_STATUS  = 10'h0cb;
	localparam logic [9:0]  IDX_RES_LOW = 10'h0cc;
	localparam logic [9:0]  IDX_RES_HIGH = 10'h0cd;

	// field positions
	localparam int          CFG_NEG_LSB   = 0;
	localparam int          CFG_LJUST_BIT = 5;
	localparam int          STAT_FLAG_BIT = 0;
	localparam int          STAT_BUSY_BIT = 1;

	// reset values
	localparam logic [7:0]  RST_LIMIT   = 8'h00;
	localparam logic [4:0]  RST_NEG_SEL = 5'h00;
	localparam logic [4:0]  RST_SAR_DIV = 5'h1f;

	// negative input code that selects ground
	localparam logic [4:0]  NEG_SEL_GND = 5'h1f;

	// converter clocks per conversion
	localparam logic [3:0]  CONV_SAR_CLOCKS = 4'h a;

	typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_e;

endpackage : adc_window_pkg

/* File: tb/adc_code_source.sv */
/*
 * Stand-in for the analog converter: offers one code per conversion.
 * Assumes the detector samples adcCode only while resultStrobe is high.
 */
`timescale 1ns/100ps
`default_nettype none

module adc_code_source
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// detector side
	input  wire logic       resultStrobe,
	input  wire logic [9:0] nextCode,
	output logic      [9:0] adcCode
);
	logic [9:0] noise_q;

	// off-strobe the code wanders, so a stale sample cannot pass
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			noise_q <= 10'h155;
		else
			noise_q <= ~noise_q ^ nextCode;
	end

	assign adcCode = resultStrobe ? nextCode : noise_q;
endmodule : adc_code_source
`default_nettype wire

/* File: tb/adc_window_detector_tb.sv */
/*
 * Self-checking bench: AXI4-Lite master, converter stand-in, window model.
 * Assumes the hand-over timing: sarDiv 0 gives ten busy cycles.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHECK(what, expv, gotv) \
	begin \
		total_checks++; \
		if ((gotv) !== (expv)) \
		begin \
			mismatches++; \
			$display("wrong value %s expected %h seen %h", what, expv, gotv); \
		end \
	end

module adc_window_detector_tb;
	logic        clk, sys_rst, convStart, convBusy, resultStrobe, flag;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic [9:0]  nextCode, adcCode;
	logic        flagModel;
	int          mismatches, total_checks, cycles;

	adc_window_detector adc_window_detector_i (.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(1'b1), .convStart(convStart), .adcCode(adcCode),
		.convBusy(convBusy), .resultStrobe(resultStrobe),
		.windowMatchFlag(flag));

	adc_code_source adc_code_source_i (.clk(clk), .sys_rst(sys_rst),
		.resultStrobe(resultStrobe), .nextCode(nextCode), .adcCode(adcCode));

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	function automatic logic [9:0] rnd10();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[9:0];
	endfunction : rnd10

	// result word layout for either justification
	function automatic logic [15:0] fmtWord(logic [9:0] v, logic lj);
		return lj ? {v, 6'h00} : {{6{v[9]}}, v};
	endfunction : fmtWord

	function automatic int valOf(logic [9:0] v, logic diff);
		return diff ? int'($signed(v)) : int'(v);
	endfunction : valOf

	task automatic busWrite(input logic [9:0] idx, input logic [7:0] val,
		input logic [3:0] strb);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h00_0000, val};
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				resp = s_axi_bresp;
				break;
			end
		end
	endtask : busWrite

	task automatic busRead(input logic [9:0] idx);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				rd = s_axi_rdata;
				resp = s_axi_rresp;
				break;
			end
		end
	endtask : busRead

	// one conversion; busy length counted from the detector's own flag
	task automatic convert(input logic [9:0] code);
		int n;
		n = 0;
		nextCode <= code;
		convStart <= 1'b1;
		@(posedge clk);
		convStart <= 1'b0;
		forever
		begin
			@(posedge clk);
			if (convBusy)
				n++;
			if (resultStrobe)
				break;
		end
		`CHECK("busy cycles", 32'd10, 32'(n))
	endtask : convert

	task automatic runCase(input logic diff, input logic lj,
		input logic [9:0] gtV, input logic [9:0] ltV);
		logic [15:0] gw, lw, w;
		logic [9:0]  codes [6];
		int          g, l, r;
		logic        hit;
		gw = fmtWord(gtV, lj);
		lw = fmtWord(ltV, lj);
		g = valOf(gtV, diff);
		l = valOf(ltV, diff);
		codes = '{gtV, gtV + 10'h001, ltV, ltV - 10'h001, rnd10(), rnd10()};
		busWrite(adc_window_pkg::IDX_GT_HIGH, gw[15:8], 4'hf);
		busWrite(adc_window_pkg::IDX_GT_LOW, gw[7:0], 4'hf);
		busWrite(adc_window_pkg::IDX_LT_HIGH, lw[15:8], 4'hf);
		busWrite(adc_window_pkg::IDX_LT_LOW, lw[7:0], 4'hf);
		busWrite(adc_window_pkg::IDX_CONFIG, {2'h0, lj,
			diff ? 5'h00 : adc_window_pkg::NEG_SEL_GND}, 4'hf);
		foreach (codes[i])
		begin
			r = valOf(codes[i], diff);
			hit = (l > g) ? (r > g && r < l) : (r < l || r > g);
			flagModel = flagModel | hit;
			convert(codes[i]);
			w = fmtWord(codes[i], lj);
			busRead(adc_window_pkg::IDX_RES_HIGH);
			`CHECK("result high", {24'h00_0000, w[15:8]}, rd)
			busRead(adc_window_pkg::IDX_RES_LOW);
			`CHECK("result low", {24'h00_0000, w[7:0]}, rd)
			busRead(adc_window_pkg::IDX_STATUS);
			`CHECK("status flag", flagModel, rd[0])
			`CHECK("match flag", flagModel, flag)
			if (i % 2 == 1)
			begin
				busWrite(adc_window_pkg::IDX_STATUS, 8'h01, 4'hf);
				flagModel = 1'b0;
				`CHECK("cleared flag", 1'b0, flag)
			end
		end
	endtask : runCase

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// hang guard, far above the roughly 800 cycles the run needs
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			final_report();
		end
	end

	initial
	begin
		{sys_rst, convStart, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h1f;
		{convStart, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		nextCode = 10'h000;
		seed = 32'h0000_25d8;
		flagModel = 1'b0;
		{mismatches, total_checks, cycles} = '0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		busRead(adc_window_pkg::IDX_LT_LOW);
		`CHECK("lt low reset", 32'h0000_0000, rd)
		busRead(adc_window_pkg::IDX_LT_HIGH);
		`CHECK("lt high reset", 32'h0000_0000, rd)
		busRead(10'h3ff);
		`CHECK("unmapped resp", adc_window_pkg::RESP_SLVERR, resp)
		busWrite(adc_window_pkg::IDX_LT_HIGH, 8'ha5, 4'hf);
		busWrite(adc_window_pkg::IDX_LT_LOW, 8'h5a, 4'h0);
		busRead(adc_window_pkg::IDX_LT_HIGH);
		`CHECK("lt high rw", 32'h0000_00a5, rd)
		busRead(adc_window_pkg::IDX_LT_LOW);
		`CHECK("lt low strobe", 32'h0000_0000, rd)
		busWrite(adc_window_pkg::IDX_RES_LOW, 8'h12, 4'hf);
		`CHECK("result write resp", adc_window_pkg::RESP_SLVERR, resp)
		busWrite(adc_window_pkg::IDX_SARDIV, 8'h00, 4'hf);
		runCase(1'b0, 1'b0, 10'h040, 10'h080);
		runCase(1'b0, 1'b0, 10'h080, 10'h040);
		runCase(1'b0, 1'b1, 10'h040, 10'h080);
		runCase(1'b1, 1'b0, 10'h3ff, 10'h040);
		runCase(1'b1, 1'b0, 10'h040, 10'h3ff);
		runCase(1'b1, 1'b1, 10'h3ff, 10'h040);
		final_report();
	end
endmodule : adc_window_detector_tb
`undef CHECK
`default_nettype wire
